// [hw/sbf_pkg.sv]
package sbf_pkg;
	// Duplex field codes that decide how the shared FIFO is split
	localparam logic [1:0] DPX_HALF_RX = 2'h1;
	localparam logic [1:0] DPX_HALF_TX = 2'h2;
	localparam logic [1:0] DPX_FULL = 2'h3;
	localparam int FIFO_BYTES = 4;
	// Receive counter points within one bit of sixteen count pulses
	localparam logic [3:0] TICK_START = 4'h1;
	localparam logic [3:0] SAMP_FIRST = 4'h6;
	localparam logic [3:0] SAMP_LAST = 4'h8;
	localparam logic [3:0] TICK_LAST = 4'hf;

	typedef struct packed {
		logic uart_mode;
		logic ext_clk;
		logic edge_fall;
		logic dbl_buf;
		logic fifo_en;
		logic [1:0] duplex;
		logic parity_en;
		logic parity_odd;
		logic rx_en;
		logic tx_en;
	} sbf_cfg_t;

	typedef struct packed {
		logic rx_buffer_full_flag;
		logic tx_buffer_empty_flag;
		logic overrun;
		logic parity_err;
		logic framing_err;
	} sbf_stat_t;

	typedef enum logic {
		URX_IDLE,
		URX_BIT
	} sbf_urx_t;
endpackage

// [hw/sbf_serial_buffer.sv]
`timescale 1ns/10ps
// Contract
// - Transmit buffer single or double by config
// - Receive double buffered in UART and external
// - FIFO needs double buffer and enable bit
// - Duplex code splits four FIFO bytes
// - Buffer flags meaningful only when double buffered
// - Receive full set on move, cleared by read
// - Transmit empty set on move, cleared by write
// - Control read clears all three error flags
// - Error flag meaning depends on mode
// - Overrun when next frame ends before read; internal clock sets it when a frame fills the buffer
// - FIFO absorbs frames, overrun only when full
// - Internal shift clock stops on overrun
// - Parity error on received parity mismatch
// - External clock underrun on edge without data
// - Internal clock underrun after output stops
// - Framing error from first stop bit only
// - Sixteen pulses per bit, majority of three
// - Internal clock samples on rising edge
// - External clock edge chosen by select bit
// - UART frame starts after valid start bit
module sbf_serial_buffer #(
	parameter int DW = 8,
	parameter int FIFO_BYTES = sbf_pkg::FIFO_BYTES
) (
	input logic sys_clk,
	input logic rst,
	input logic ext_sclk,
	input sbf_pkg::sbf_cfg_t cfg,
	input logic rxd,
	input logic count_tick,
	input logic wr_buf,
	input logic [DW-1:0] wr_data,
	input logic rd_buf,
	input logic rd_ctrl,
	input logic rx_fifo_clear,
	input logic tx_fifo_clear,
	input logic tx_take,
	output logic [DW-1:0] rx_data,
	output sbf_pkg::sbf_stat_t status,
	output logic [DW-1:0] tx_word,
	output logic tx_word_valid,
	output logic sclk_out,
	output logic sclk_oe_n,
	output logic io_txd,
	output logic ext_txd
);
	localparam int QD = FIFO_BYTES + 1;
	localparam int CW = $clog2(QD + 1);
	localparam int BW = $clog2(DW);
	localparam logic [CW-1:0] BUF_STAGE = CW'(1);
	localparam logic [BW-1:0] BIT_LAST = BW'(DW - 1);
	localparam logic [3:0] DATA_LAST = 4'(DW);
	localparam logic [3:0] PAR_IDX = 4'(DW + 1);

	typedef logic [QD-1:0][DW-1:0] sbf_q_t;

	typedef struct packed {
		logic rxd_m;
		logic rxd_s;
		logic [2:0] rtog_s;
		logic [2:0] ack_s;
		logic [2:0] urun_s;
		sbf_q_t rxq;
		sbf_q_t txq;
		logic [CW-1:0] rxn;
		logic [CW-1:0] txn;
		logic req;
		logic txv;
		sbf_pkg::sbf_stat_t st;
		sbf_pkg::sbf_urx_t ust;
		logic [3:0] ucnt;
		logic [2:0] samp;
		logic [3:0] ubit;
		logic [DW-1:0] ush;
		logic upar;
		logic run;
		logic sclk;
		logic oe_n;
		logic [BW-1:0] ibit;
		logic [DW-1:0] irx;
		logic [DW-1:0] itx;
		logic txd;
	} sbf_sys_t;

	typedef struct packed {
		logic rst_m;
		logic rst_s;
		logic req_m;
		logic req_s;
		logic [1:0] mode_m;
		logic [1:0] mode_s;
		logic [BW-1:0] bcnt;
		logic [DW-1:0] rxsh;
		logic [DW-1:0] rxw;
		logic rtog;
		logic ack;
		logic urun;
		logic [DW-1:0] txsh;
		logic txd;
	} sbf_lnk_t;

	sbf_sys_t s;
	sbf_sys_t n;
	sbf_lnk_t l;
	sbf_lnk_t ln;
	logic fall_q;

	// Bytes of the shared FIFO that one direction owns
	function automatic logic [CW-1:0] fifo_share(input logic [1:0] dpx, input logic rx);
		fifo_share = '0;
		case (dpx)
			sbf_pkg::DPX_HALF_RX: begin
				if (rx) begin
					fifo_share = CW'(FIFO_BYTES);
				end
			end
			sbf_pkg::DPX_HALF_TX: begin
				if (!rx) begin
					fifo_share = CW'(FIFO_BYTES);
				end
			end
			sbf_pkg::DPX_FULL: begin
				fifo_share = CW'(FIFO_BYTES / 2);
			end
			default: begin
				fifo_share = '0;
			end
		endcase
	endfunction

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Head sits at index 0; a pop shifts everything down one place
	function automatic sbf_q_t q_upd(input sbf_q_t q, input logic [CW-1:0] cnt,
			input logic pop, input logic push, input logic [DW-1:0] d);
		sbf_q_t r;
		logic [CW-1:0] k;
		r = q;
		k = cnt;
		if (pop) begin
			r = {{DW{1'h0}}, q[QD-1:1]};
			k = cnt - BUF_STAGE;
		end
		if (push) begin
			r[k] = d;
		end
		q_upd = r;
	endfunction

	always_comb begin
		logic fifo_on;
		logic rx_dbl;
		logic io_ext;
		logic io_int;
		logic [CW-1:0] rx_cap;
		logic [CW-1:0] tx_cap;
		logic rx_push;
		logic rx_ok;
		logic [DW-1:0] rx_d;
		logic rx_pop;
		logic tx_pop;
		logic tx_push;
		logic set_o;
		logic set_p;
		logic set_f;
		logic m;
		logic go;
		logic rx_stop;
		logic tx_stop;
		n = s;
		rx_push = 1'h0;
		rx_ok = 1'h0;
		rx_d = '0;
		tx_pop = 1'h0;
		set_o = 1'h0;
		set_p = 1'h0;
		set_f = 1'h0;
		m = 1'h0;
		go = 1'h0;
		rx_stop = 1'h0;
		tx_stop = 1'h0;
		io_ext = !cfg.uart_mode & cfg.ext_clk;
		io_int = !cfg.uart_mode & !cfg.ext_clk;
		fifo_on = cfg.dbl_buf & cfg.fifo_en;
		rx_dbl = cfg.uart_mode | cfg.ext_clk | cfg.dbl_buf;
		rx_cap = BUF_STAGE + (fifo_on ? fifo_share(cfg.duplex, 1'h1) : '0);
		tx_cap = BUF_STAGE + (fifo_on ? fifo_share(cfg.duplex, 1'h0) : '0);
		rx_pop = rd_buf & (s.rxn != '0);
		// single stage refuses a write while the shifter is busy
		tx_push = wr_buf & (s.txn < tx_cap) & (cfg.dbl_buf | !s.run);

		n.rxd_m = rxd;
		n.rxd_s = s.rxd_m;
		n.rtog_s = {s.rtog_s[1:0], l.rtog};
		n.ack_s = {s.ack_s[1:0], l.ack};
		n.urun_s = {s.urun_s[1:0], l.urun};

		if (cfg.uart_mode && tx_take && s.txn != '0) begin
			tx_pop = 1'h1;
		end

		if (io_ext) begin
			// Link word stays put until the next frame ends, long after this edge
			if (s.rtog_s[2] != s.rtog_s[1]) begin
				rx_push = 1'h1;
				rx_d = l.rxw;
			end
			if (s.ack_s[2] != s.ack_s[1]) begin
				tx_pop = 1'h1;
			end else if (s.req == s.ack_s[1] && s.txn != '0) begin
				n.req = !s.req;
			end
			if (s.urun_s[2] != s.urun_s[1]) begin
				set_p = cfg.dbl_buf;
			end
		end

		if (cfg.uart_mode && count_tick) begin
			case (s.ust)
				sbf_pkg::URX_IDLE: begin
					if (!s.rxd_s) begin
						n.ust = sbf_pkg::URX_BIT;
						n.ucnt = sbf_pkg::TICK_START;
						n.ubit = '0;
						n.upar = 1'h0;
					end
				end
				sbf_pkg::URX_BIT: begin
					n.ucnt = s.ucnt + 4'h1;
					if (s.ucnt >= sbf_pkg::SAMP_FIRST && s.ucnt <= sbf_pkg::SAMP_LAST) begin
						n.samp = {s.samp[1:0], s.rxd_s};
					end
					if (s.ucnt == sbf_pkg::TICK_LAST) begin
						n.ubit = s.ubit + 4'h1;
					end
					if (s.ucnt == sbf_pkg::SAMP_LAST) begin
						m = maj3({s.samp[1:0], s.rxd_s});
						if (s.ubit == '0) begin
							if (m) begin
								n.ust = sbf_pkg::URX_IDLE;
							end
						end else if (s.ubit <= DATA_LAST) begin
							n.ush = {m, s.ush[DW-1:1]};
							n.upar = s.upar ^ m;
						end else if (s.ubit == PAR_IDX && cfg.parity_en) begin
							n.upar = s.upar ^ m;
						end else begin
							// Decided at centre so the next start edge is not missed
							rx_push = 1'h1;
							rx_d = s.ush;
							set_f = !m;
							set_p = cfg.parity_en & (s.upar != cfg.parity_odd);
							n.ust = sbf_pkg::URX_IDLE;
						end
					end
				end
				default: begin
					n.ust = sbf_pkg::URX_IDLE;
				end
			endcase
		end

		if (io_int) begin
			n.oe_n = 1'h0;
			go = (cfg.rx_en | cfg.tx_en) & (!cfg.rx_en | (s.rxn < rx_cap)) &
				(!cfg.tx_en | (s.txn != '0));
			if (!s.run) begin
				n.sclk = 1'h1;
				if (go && count_tick) begin
					n.run = 1'h1;
					n.ibit = '0;
					if (cfg.tx_en) begin
						tx_pop = 1'h1;
						n.itx = s.txq[0];
					end
				end
			end else if (count_tick) begin
				n.sclk = !s.sclk;
				if (s.sclk) begin
					n.txd = s.itx[s.ibit];
				end else begin
					n.irx = {s.rxd_s, s.irx[DW-1:1]};
					n.ibit = s.ibit + BW'(1);
					if (s.ibit == BIT_LAST) begin
						n.ibit = '0;
						if (cfg.rx_en) begin
							rx_push = 1'h1;
							rx_d = {s.rxd_s, s.irx[DW-1:1]};
						end
						rx_stop = cfg.rx_en & ((s.rxn + BUF_STAGE) >= rx_cap);
						tx_stop = cfg.tx_en & (s.txn == '0);
						if (rx_stop || tx_stop) begin
							n.run = 1'h0;
							set_o = rx_stop;
							set_p = tx_stop & cfg.dbl_buf;
						end else if (cfg.tx_en) begin
							tx_pop = 1'h1;
							n.itx = s.txq[0];
						end
					end
				end
			end
		end else begin
			n.run = 1'h0;
			n.sclk = 1'h1;
			n.oe_n = 1'h1;
		end

		if (rx_push) begin
			// overrun keeps buffer, drops the new frame
			if ((s.rxn - CW'(rx_pop)) >= rx_cap) begin
				set_o = 1'h1;
			end else begin
				rx_ok = 1'h1;
			end
		end
		n.rxq = q_upd(s.rxq, s.rxn, rx_pop, rx_ok, rx_d);
		n.rxn = s.rxn - CW'(rx_pop) + CW'(rx_ok);
		n.txq = q_upd(s.txq, s.txn, tx_pop, tx_push, wr_data);
		n.txn = s.txn - CW'(tx_pop) + CW'(tx_push);
		if (rx_fifo_clear) begin
			n.rxn = '0;
		end
		if (tx_fifo_clear) begin
			n.txn = '0;
		end

		// read clears, a same-cycle event still wins
		n.st.overrun = (s.st.overrun & !rd_ctrl) | set_o;
		n.st.parity_err = (s.st.parity_err & !rd_ctrl) | set_p;
		n.st.framing_err = (s.st.framing_err & !rd_ctrl) | (set_f & cfg.uart_mode);
		n.st.rx_buffer_full_flag = rx_dbl & (n.rxn != '0);
		n.st.tx_buffer_empty_flag = cfg.dbl_buf & (n.txn == '0);
		n.txv = n.txn != '0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.sclk <= 1'h1;
			s.oe_n <= 1'h1;
			s.txd <= 1'h1;
		end else begin
			s <= n;
		end
	end

	// Falling-edge copy lets the posedge logic honour the edge select
	always_ff @(negedge ext_sclk) begin
		fall_q <= rxd;
	end

	// Link state only advances while the far side clocks it
	always_comb begin
		logic b;
		ln = l;
		ln.rst_m = rst;
		ln.rst_s = l.rst_m;
		ln.req_m = s.req;
		ln.req_s = l.req_m;
		ln.mode_m = {!cfg.uart_mode & cfg.ext_clk, cfg.edge_fall};
		ln.mode_s = l.mode_m;
		b = l.mode_s[0] ? fall_q : rxd;
		if (l.rst_s) begin
			ln.bcnt = '0;
			ln.rxsh = '0;
			ln.rxw = '0;
			ln.rtog = 1'h0;
			ln.ack = 1'h0;
			ln.urun = 1'h0;
			ln.txsh = '0;
			ln.txd = 1'h1;
		end else if (l.mode_s[1]) begin
			ln.rxsh = {b, l.rxsh[DW-1:1]};
			ln.bcnt = l.bcnt + BW'(1);
			if (l.bcnt == BIT_LAST) begin
				ln.rxw = {b, l.rxsh[DW-1:1]};
				ln.rtog = !l.rtog;
			end
			if (l.bcnt == '0) begin
				if (l.req_s != l.ack) begin
					ln.ack = !l.ack;
					ln.txsh = s.txq[0];
					ln.txd = s.txq[0][0];
				end else begin
					ln.urun = !l.urun;
					ln.txsh = '1;
					ln.txd = 1'h1;
				end
			end else begin
				ln.txd = l.txsh[l.bcnt];
			end
		end
	end

	always_ff @(posedge ext_sclk) begin
		l <= ln;
	end

	assign rx_data = s.rxq[0];
	assign status = s.st;
	assign tx_word = s.txq[0];
	assign tx_word_valid = s.txv;
	assign sclk_out = s.sclk;
	assign sclk_oe_n = s.oe_n;
	assign io_txd = s.txd;
	assign ext_txd = l.txd;
endmodule

// [verif/sbf_serial_buffer_sva.sv]
`timescale 1ns/10ps
module sbf_serial_buffer_sva #(
	parameter int DW = 8
) (
	input logic sys_clk,
	input logic rst,
	input sbf_pkg::sbf_cfg_t cfg,
	input logic count_tick,
	input logic wr_buf,
	input logic [DW-1:0] wr_data,
	input logic rd_buf,
	input logic rd_ctrl,
	input logic tx_fifo_clear,
	input logic tx_take,
	input sbf_pkg::sbf_stat_t status,
	input logic [DW-1:0] tx_word,
	input logic tx_word_valid,
	input logic sclk_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A write into an empty double buffer that nothing else disturbs
	sequence s_wr_empty;
		wr_buf && cfg.dbl_buf && !tx_word_valid && !tx_take && !tx_fifo_clear;
	endsequence
	a_err_clear: assert property (rd_ctrl && cfg.uart_mode && !count_tick |=>
		!status.overrun && !status.parity_err && !status.framing_err)
		else $error("error flags kept after control read");
	a_fe_io: assert property (rd_ctrl && !cfg.uart_mode |=> !status.framing_err)
		else $error("framing flag set in shift mode");
	a_fe_hold: assert property (!cfg.uart_mode && !status.framing_err |=>
		!status.framing_err)
		else $error("framing flag rose in shift mode");
	a_te_meaning: assert property (!$past(rst) && $past(cfg.dbl_buf) && !tx_word_valid
		|-> status.tx_buffer_empty_flag)
		else $error("empty flag low with empty double buffer");
	a_wr_show: assert property (s_wr_empty |=> tx_word_valid
		&& !status.tx_buffer_empty_flag && tx_word == $past(wr_data))
		else $error("write not shown in transmit buffer");
	a_take_empty: assert property (tx_take && cfg.uart_mode && cfg.dbl_buf
		&& !cfg.fifo_en && !wr_buf |=> status.tx_buffer_empty_flag && !tx_word_valid)
		else $error("empty flag not set after move to shifter");
	a_rd_full: assert property (rd_buf && cfg.uart_mode && !cfg.fifo_en && !count_tick
		|=> !status.rx_buffer_full_flag)
		else $error("full flag kept after buffer read");
	a_sclk_stop: assert property ($rose(status.overrun) && !cfg.uart_mode
		&& !cfg.ext_clk |-> sclk_out [*4])
		else $error("shift clock runs after overrun");
endmodule

bind sbf_serial_buffer sbf_serial_buffer_sva #(.DW(DW)) i_sva (.*);

// [verif/sbf_far_end.sv]
`timescale 1ns/10ps
module sbf_far_end (
	input logic sys_clk,
	output logic rxd,
	output logic ext_sclk
);
	initial begin
		rxd = 1'h1;
		ext_sclk = 1'h1;
	end
	// Short stop so a low stop bit cannot pose as a start
	task automatic uart(input logic [10:0] bits);
		for (int i = 0; i < 11; i++) begin
			rxd = bits[i];
			repeat (i == 10 ? 20 : 32) @(negedge sys_clk);
		end
		rxd = 1'h1;
	endtask
	task automatic glitch;
		rxd = 1'h0;
		repeat (3) @(negedge sys_clk);
		rxd = 1'h1;
	endtask
	// Shift clock stands high outside frames
	task automatic frame(input logic [7:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			#23 ext_sclk = 1'h0;
			rxd = d[i];
			#40 ext_sclk = 1'h1;
			#17;
		end
		rxd = 1'h1;
	endtask
endmodule

// [verif/sbf_serial_buffer_test.sv]
`timescale 1ns/10ps
module sbf_serial_buffer_test;
	logic sys_clk, rst, ext_sclk, rxd, count_tick, wr_buf, rd_buf, rd_ctrl;
	logic rx_fifo_clear, tx_fifo_clear, tx_take, tx_word_valid;
	logic sclk_out, sclk_oe_n, io_txd, ext_txd;
	logic [7:0] wr_data, rx_data, tx_word, d;
	sbf_pkg::sbf_cfg_t cfg;
	sbf_pkg::sbf_stat_t status;
	int err_total, checked, seed, n, cap;
	logic [7:0] q[$];
	sbf_serial_buffer i_dut (.*);
	sbf_far_end i_far (.*);
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) count_tick <= ~count_tick;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic wait_stat(input int b);
		for (n = 0; n < 400 && status[b] !== 1'b1; n++)
			cyc(1);
		if (n == 400) begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic send(input logic [7:0] v, input logic pbad, input logic stp);
		i_far.uart({stp, ^v ^ pbad, v, 1'b0});
		cyc(24);
	endtask
	initial begin
		seed = 5;
		err_total = 0;
		checked = 0;
		{rst, count_tick, wr_buf, rd_buf, rd_ctrl} = 5'h10;
		{rx_fifo_clear, tx_fifo_clear, tx_take, wr_data} = '0;
		cfg = '0;
		cfg.ext_clk = 1'h1;
		cfg.dbl_buf = 1'h1;
		fork
			cyc(8);
			i_far.frame(8'hff, 2);
		join
		rst = 1'h0;
		cyc(2);
		chk("tx empty", status.tx_buffer_empty_flag, 1);
		// Link reset releases two shift clocks late, so idle edges go first
		i_far.frame(8'hff, 2);
		d = 8'($random(seed));
		i_far.frame(d, 8);
		wait_stat(4);
		q.push_back(d);
		chk("ext rx", rx_data, q.pop_front());
		chk("underrun", status.parity_err, 1);
		chk("ext txd", ext_txd, 1);
		cfg = '0;
		cfg.uart_mode = 1'h1;
		cfg.parity_en = 1'h1;
		rd_buf = 1'h1;
		rd_ctrl = 1'h1;
		cyc(2);
		{rd_buf, rd_ctrl} = 2'h0;
		cyc(1);
		chk("full clr", status.rx_buffer_full_flag, 0);
		chk("err clr", status[2:0], 0);
		i_far.glitch();
		cyc(40);
		chk("no frame", status.rx_buffer_full_flag, 0);
		for (int k = 0; k < 3; k++) begin
			d = 8'($random(seed));
			send(d, k == 1, k != 1);
			if (q.size() == 0)
				q.push_back(d);
			chk("uart rx", rx_data, q[0]);
			chk("full", status.rx_buffer_full_flag, 1);
			chk("uart err", status[2:0], {k == 2, k > 0, k > 0});
			if (k == 0) begin
				rd_buf = 1'h1;
				cyc(2);
				rd_buf = 1'h0;
				void'(q.pop_front());
			end
		end
		rd_ctrl = 1'h1;
		cyc(2);
		rd_ctrl = 1'h0;
		cyc(1);
		chk("err clr", status[2:0], 0);
		for (int i = 0; i < 5; i++) begin
			cfg.dbl_buf = i < 4;
			cfg.fifo_en = i != 0;
			cfg.duplex = i == 4 ? 2'h2 : 2'(i);
			cap = 1 + (i == 2 ? 4 : i == 3 ? 2 : 0);
			// transmit queue emptied after the split is chosen
			tx_fifo_clear = 1'h1;
			cyc(1);
			tx_fifo_clear = 1'h0;
			q.delete();
			for (int k = 0; k < 6; k++) begin
				wr_data = 8'($random(seed));
				wr_buf = 1'h1;
				if (q.size() < cap)
					q.push_back(wr_data);
				cyc(1);
			end
			wr_buf = 1'h0;
			cyc(1);
			chk("tx full", status.tx_buffer_empty_flag, 0);
			while (q.size() > 0) begin
				chk("tx word", tx_word, q.pop_front());
				tx_take = 1'h1;
				cyc(1);
				tx_take = 1'h0;
				cyc(1);
			end
			chk("tx drained", {tx_word_valid, status.tx_buffer_empty_flag}, {1'b0, i < 4});
		end
		cfg = '0;
		cfg.dbl_buf = 1'h1;
		cfg.rx_en = 1'h1;
		cfg.tx_en = 1'h1;
		{rx_fifo_clear, tx_fifo_clear} = 2'h3;
		cyc(1);
		{rx_fifo_clear, tx_fifo_clear} = 2'h0;
		wr_data = 8'($random(seed));
		wr_buf = 1'h1;
		cyc(1);
		wr_buf = 1'h0;
		wait_stat(2);
		cyc(6);
		chk("int rx", rx_data, 8'hff);
		chk("int stop", {sclk_out, status.parity_err}, 2'h3);
		chk("int oe", sclk_oe_n, 0);
		chk("int txd", io_txd, wr_data[7]);
		// flags read before leaving this mode
		rd_ctrl = 1'h1;
		cyc(2);
		rd_ctrl = 1'h0;
		cyc(1);
		stop_test();
	end
endmodule
